// >>> design/edm_pkg.sv
/*
 * edm_pkg: shared constants, types and state codes for the four-channel
 * external-bus dma channel-state and priority block.
 * assumes: included by name (edm_pkg::) from the design and the bench; no imports.
 */
package edm_pkg;

   localparam int          NUM_CH    = 4;            // channels, 0 highest priority
   localparam int          AW        = 32;           // address register width
   localparam int          CW        = 24;           // transfer count width
   localparam int          BLK_LSB   = 16;           // block size field starts here
   localparam int          BW        = 9;            // block remainder counter width

   // software register selects on the write and read ports
   localparam logic [2:0]  SEL_SAR   = 3'h0;         // source_address_reg
   localparam logic [2:0]  SEL_DAR   = 3'h1;         // destination_address_reg
   localparam logic [2:0]  SEL_TCR   = 3'h2;         // transfer_count_reg
   localparam logic [2:0]  SEL_MODE  = 3'h3;         // channel_mode_reg
   localparam logic [2:0]  SEL_ACR   = 3'h4;         // address_control_reg

   // address step modes (hi, lo)
   localparam logic [1:0]  STEP_INC  = 2'h2;         // hi=1 lo=0 : increment
   localparam logic [1:0]  STEP_DEC  = 2'h3;         // hi=1 lo=1 : decrement
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;
   localparam logic [8:0]  BLK_FULL  = 9'h100;       // block size code 0 means 256

   // reset values
   localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
   localparam logic [23:0] TCR_RST   = 24'h00_0000;
   localparam logic [31:0] RD_RST    = 32'h0000_0000;

   // channel_mode_reg, bit 0 upward: channel_enable_bit first
   typedef struct packed {
      logic auto_req;                               // bit 7: auto request activation
      logic burst;                                  // bit 6: burst bus mode
      logic blk;                                    // bit 5: block transfer mode
      logic size;                                   // bit 4: transfer_size_bit, 1 = word
      logic bef;                                    // bit 3: block_error_flag
      logic interrupt_request_flag;                                    // bit 2: interrupt_request_flag
      logic ie;                                     // bit 1: interrupt_enable_bit
      logic en;                                     // bit 0: channel_enable_bit
   } edm_mode_t;

   // address_control_reg, low 16 bits
   typedef struct packed {
      logic       sarie;                            // bit 15: source repeat overflow irq
      logic       darie;                            // bit 14: destination repeat overflow irq
      logic [4:0] sara;                             // bits 13:9: source repeat area bits
      logic [4:0] dara;                             // bits 8:4: destination repeat area bits
      logic [1:0] sat;                              // bits 3:2: source step mode hi, lo
      logic [1:0] dat;                              // bits 1:0: destination step mode hi, lo
   } edm_acr_t;

   localparam edm_mode_t   MODE_RST  = '0;
   localparam edm_acr_t    ACR_RST   = '0;

   // software write request, one cycle
   typedef struct packed {
      logic        wr;                              // write strobe
      logic [1:0]  ch;                              // channel
      logic [2:0]  sel;                             // register select
      logic [31:0] data;                            // write data
   } edm_swr_t;

   // transfer engine states, gray along idle -> read -> write -> release
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD   = 2'b01,
      ST_WR   = 2'b11,
      ST_REL  = 2'b10
   } edm_state_t;

endpackage : edm_pkg

// >>> design/edm_core.sv
/*
 * edm_core: per-channel register update and priority channel arbitration, where the
 * current channel yields to any other requester outside auto cycle steal, of a four-channel external-bus dma unit.
 * assumes: all inputs are synchronous to sys_clk; each bus cycle takes one
 * clock; the bus is free whenever bus_other_req is low.
 */
`timescale 1ns/1ps

module edm_core #(
   parameter int NCH = edm_pkg::NUM_CH                   // channel count
) (
   input  wire logic                sys_clk,             // 100 MHz system clock
   input  wire logic                nrst,                // async reset, active low
   input  wire edm_pkg::edm_swr_t   sw_wr,               // processor register write
   input  wire logic                sw_rd,               // processor longword read strobe
   input  wire logic [1:0]          sw_rd_ch,            // read channel
   input  wire logic [2:0]          sw_rd_sel,           // read register select
   input  wire logic [NCH-1:0]      xfer_req,            // per-channel transfer requests
   input  wire logic                bus_other_req,       // another master wants the bus
   input  wire logic                nmi,                 // nmi event, one cycle
   input  wire logic                hw_standby,          // hardware standby level
   output logic [31:0]              rd_data_r,           // buffered read data
   output logic [31:0]              bus_addr_r,          // dma bus address
   output logic                     bus_rd_r,            // dma read cycle
   output logic                     bus_wr_r,            // dma write cycle
   output logic                     bus_size_r,          // 1 = word cycle
   output logic [1:0]               bus_ch_r,            // channel owning the cycle
   output logic                     xfer_end_r,          // last transfer pulse
   output logic [NCH-1:0]           ch_en_r,             // channel enable bits
   output logic [NCH-1:0]           irq_r                // interrupt requests
);

   // address step with repeat area; msb of the result flags an overflow
   function automatic logic [32:0] edm_step(input logic [31:0] a, input logic [1:0] md,
                                           input logic sz, input logic [4:0] ara);
      logic [31:0] d;
      logic [31:0] nx;
      logic [31:0] m;
      d  = sz ? edm_pkg::STEP_WORD : edm_pkg::STEP_BYTE;
      nx = (md == edm_pkg::STEP_INC) ? a + d :
           (md == edm_pkg::STEP_DEC) ? a - d : a;
      m  = (ara == 5'h00) ? edm_pkg::ALL_ONES : ((32'h0000_0001 << ara) - 32'h0000_0001);
      edm_step = {|((nx ^ a) & ~m), (a & ~m) | (nx & m)};
   endfunction : edm_step

   // highest-priority set bit: {valid, index}
   function automatic logic [2:0] edm_pick(input logic [NCH-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int k = NCH - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = {1'b1, 2'(k)};
         end
      end
      edm_pick = r;
   endfunction : edm_pick

   edm_pkg::edm_state_t  st_r, st_nxt;
   logic [1:0]           cur_r, cur_nxt;
   logic [8:0]           blk_rem_r, blk_rem_nxt;

   logic [31:0]          sar_w   [NCH];
   logic [31:0]          dar_w   [NCH];
   logic [23:0]          tcr_w   [NCH];
   edm_pkg::edm_mode_t   mode_w  [NCH];
   edm_pkg::edm_acr_t    acr_w   [NCH];
   logic [NCH-1:0]       halt_w;
   logic [NCH-1:0]       chan_end_w;

   // engine decode
   wire       in_rd     = (st_r == edm_pkg::ST_RD);
   wire       in_wr     = (st_r == edm_pkg::ST_WR);
   wire       blk_last  = (blk_rem_r == 9'h001);
   wire       unit_done = in_wr && (!mode_w[cur_r].blk || blk_last);
   wire       abort     = nmi || hw_standby;

   // per-channel register sets, each touched only by its own transfers, processor writes to its channel and nmi or standby
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [31:0]        sar_r, dar_r;
      logic [23:0]        tcr_r;
      edm_pkg::edm_mode_t mode_r;
      edm_pkg::edm_acr_t  acr_r;
      logic               halt_r, ovf_r;

      wire        me      = (cur_r == 2'(i));
      wire        busy    = me && (in_rd || in_wr);
      wire        rd_hit  = me && in_rd;
      wire        wr_hit  = me && in_wr;
      wire        done    = me && unit_done;
      wire        sel_me  = sw_wr.wr && (sw_wr.ch == 2'(i));
      wire        wr_sar  = sel_me && (sw_wr.sel == edm_pkg::SEL_SAR);
      wire        wr_dar  = sel_me && (sw_wr.sel == edm_pkg::SEL_DAR);
      wire        wr_tcr  = sel_me && (sw_wr.sel == edm_pkg::SEL_TCR);
      wire        wr_mode = sel_me && (sw_wr.sel == edm_pkg::SEL_MODE);
      wire        wr_acr  = sel_me && (sw_wr.sel == edm_pkg::SEL_ACR) && !mode_r.en;
      wire [32:0] s_step  = edm_step(sar_r, acr_r.sat, mode_r.size, acr_r.sara);
      wire [32:0] d_step  = edm_step(dar_r, acr_r.dat, mode_r.size, acr_r.dara);
      wire        s_ovf   = rd_hit && acr_r.sarie && s_step[32];
      wire        d_ovf   = wr_hit && acr_r.darie && d_step[32];

      // count: block mode counts only the low 16 bits and keeps the block size
      wire [15:0] lo_cnt  = tcr_r[15:0];
      wire        cnt_one = mode_r.blk ? (lo_cnt == 16'h0001) : (tcr_r == 24'h00_0001);
      wire [23:0] tcr_dec = mode_r.blk ?
                            {tcr_r[23:16], (lo_cnt == 16'h0000) ? lo_cnt : lo_cnt - 16'h0001}
                          : (tcr_r == edm_pkg::TCR_RST) ? tcr_r : tcr_r - 24'h00_0001;
      wire        tc_end  = wr_hit && cnt_one && !(wr_tcr && sw_wr.data[23:0] == 24'h00_0000);
      logic       tc_pend_r;

      // an end condition met inside a block waits for the block to finish
      wire        stop_ev = tc_end || tc_pend_r || s_ovf || d_ovf || ovf_r;
      wire        fin     = done && (stop_ev || halt_r);
      wire        irf_set = done && stop_ev;
      wire        en_one  = wr_mode && sw_wr.data[0];
      wire        en_zero = wr_mode && !sw_wr.data[0] && mode_r.en;
      wire        bef_set = nmi && busy && mode_r.blk;

      // processor writes win over the same-cycle dma update
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            sar_r <= edm_pkg::ADDR_RST;
            dar_r <= edm_pkg::ADDR_RST;
            tcr_r <= edm_pkg::TCR_RST;
         end else begin
            sar_r <= wr_sar ? sw_wr.data : rd_hit ? s_step[31:0] : sar_r;
            dar_r <= wr_dar ? sw_wr.data : wr_hit ? d_step[31:0] : dar_r;
            tcr_r <= wr_tcr ? sw_wr.data[23:0] : wr_hit ? tcr_dec : tcr_r;
         end
      end

      // overflow and count end held until the unit finishes
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            ovf_r     <= 1'b0;
            tc_pend_r <= 1'b0;
         end else begin
            ovf_r     <= (ovf_r || s_ovf || d_ovf) && !done && !abort;
            tc_pend_r <= (tc_pend_r || tc_end) && !done && !abort;
         end
      end

      // halt request: a 0-write only takes effect at the unit boundary
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            halt_r <= 1'b0;
         end else begin
            halt_r <= (halt_r || en_zero) && !en_one && !fin && !abort && mode_r.en;
         end
      end

      // mode register: enable clear on every end cause, clear beats set
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            mode_r <= edm_pkg::MODE_RST;
         end else begin
            if (wr_mode && !mode_r.en) begin
               {mode_r.auto_req, mode_r.burst, mode_r.blk, mode_r.size, mode_r.ie} <=
                  {sw_wr.data[7:4], sw_wr.data[1]};
            end
            if (abort || fin || (halt_r && !busy)) begin
               mode_r.en <= 1'b0;
            end else if (en_one) begin
               mode_r.en <= 1'b1;
            end
            if (irf_set) begin
               mode_r.interrupt_request_flag <= 1'b1;
            end else if (en_one) begin
               mode_r.interrupt_request_flag <= 1'b0;
            end
            if (bef_set) begin
               mode_r.bef <= 1'b1;
            end else if (wr_mode && !sw_wr.data[3]) begin
               mode_r.bef <= 1'b0;
            end
         end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            acr_r <= edm_pkg::ACR_RST;
         end else if (wr_acr) begin
            acr_r <= sw_wr.data[15:0];
         end
      end

      // request output registered; drops with the flag or the interrupt enable bit
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            irq_r[i] <= 1'b0;
         end else begin
            irq_r[i] <= (mode_r.interrupt_request_flag || irf_set) && mode_r.ie && !(en_one && !irf_set);
         end
      end

      assign sar_w[i]      = sar_r;
      assign dar_w[i]      = dar_r;
      assign tcr_w[i]      = tcr_r;
      assign mode_w[i]     = mode_r;
      assign acr_w[i]      = acr_r;
      assign halt_w[i]     = halt_r;
      assign chan_end_w[i] = fin || abort;
      assign ch_en_r[i]    = mode_r.en;
   end : g_ch

   // arbitration: halting channels take no new units
   logic [NCH-1:0] req_ok;
   always_comb begin
      req_ok = '0;
      for (int k = 0; k < NCH; k++) begin
         req_ok[k] = xfer_req[k] && mode_w[k].en && !halt_w[k];
      end
   end

   wire [2:0]     pick_all  = edm_pick(req_ok);
   wire [NCH-1:0] cur_1hot  = NCH'(1) << cur_r;
   wire [2:0]     pick_oth  = edm_pick(req_ok & ~cur_1hot);
   wire           cur_ascs  = mode_w[cur_r].auto_req && !mode_w[cur_r].burst;
   // auto cycle steal keeps the current channel unless a higher one asks
   wire [2:0]     pick      = cur_ascs ? pick_all :
                              pick_oth[2] ? pick_oth : pick_all;
   wire           keep_blk  = mode_w[cur_r].blk && !blk_last && mode_w[cur_r].en && !abort;
   wire           keep_bst  = mode_w[cur_r].burst && !chan_end_w[cur_r] && mode_w[cur_r].en;
   wire [8:0]     blk_size  = (tcr_w[pick[1:0]][23:16] == 8'h00) ? edm_pkg::BLK_FULL
                              : {1'b0, tcr_w[pick[1:0]][23:16]};

   // engine next state: one clock per bus cycle, release after each unit except in non-block burst mode
   always_comb begin
      st_nxt      = st_r;
      cur_nxt     = cur_r;
      blk_rem_nxt = blk_rem_r;
      unique case (st_r)
         edm_pkg::ST_IDLE: begin
            if (pick[2] && !bus_other_req && !abort) begin
               st_nxt      = edm_pkg::ST_RD;
               cur_nxt     = pick[1:0];
               blk_rem_nxt = blk_size;
            end
         end
         edm_pkg::ST_RD: begin
            st_nxt = edm_pkg::ST_WR;
         end
         edm_pkg::ST_WR: begin
            blk_rem_nxt = blk_rem_r - 9'h001;
            if (keep_blk || (keep_bst && !mode_w[cur_r].blk)) begin
               st_nxt = edm_pkg::ST_RD;
            end else begin
               st_nxt = edm_pkg::ST_REL;
            end
         end
         edm_pkg::ST_REL: begin
            if (!bus_other_req) begin
               st_nxt = edm_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r      <= edm_pkg::ST_IDLE;
         cur_r     <= 2'h0;
         blk_rem_r <= 9'h000;
      end else begin
         st_r      <= st_nxt;
         cur_r     <= cur_nxt;
         blk_rem_r <= blk_rem_nxt;
      end
   end

   // bus cycle outputs follow the next state so they line up with it
   wire next_rd = (st_nxt == edm_pkg::ST_RD);
   wire next_wr = (st_nxt == edm_pkg::ST_WR);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_addr_r <= edm_pkg::ADDR_RST;
         bus_rd_r   <= 1'b0;
         bus_wr_r   <= 1'b0;
         bus_size_r <= 1'b0;
         bus_ch_r   <= 2'h0;
      end else begin
         bus_addr_r <= next_rd ? sar_w[cur_nxt] : next_wr ? dar_w[cur_nxt] : bus_addr_r;
         bus_rd_r   <= next_rd;
         bus_wr_r   <= next_wr;
         bus_size_r <= mode_w[cur_nxt].size;
         bus_ch_r   <= cur_nxt;
      end
   end

   // read snapshot: whole word captured in one edge, so halves always match
   wire [31:0] rd_mux =
      (sw_rd_sel == edm_pkg::SEL_SAR)  ? sar_w[sw_rd_ch] :
      (sw_rd_sel == edm_pkg::SEL_DAR)  ? dar_w[sw_rd_ch] :
      (sw_rd_sel == edm_pkg::SEL_TCR)  ? {8'h00, tcr_w[sw_rd_ch]} :
      (sw_rd_sel == edm_pkg::SEL_MODE) ? {24'h00_0000, mode_w[sw_rd_ch]} :
      (sw_rd_sel == edm_pkg::SEL_ACR)  ? {16'h0000, acr_w[sw_rd_ch]} : 32'h0000_0000;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_r  <= edm_pkg::RD_RST;
         xfer_end_r <= 1'b0;
      end else begin
         if (sw_rd) begin
            rd_data_r <= rd_mux;
         end
         xfer_end_r <= in_wr && (tcr_w[cur_r][15:0] == 16'h0001) &&
                       (mode_w[cur_r].blk || tcr_w[cur_r][23:16] == 8'h00);
      end
   end

endmodule : edm_core

// >>> bench/edm_mem.sv
/* edm_mem: far-side memory and other-master model for edm_core.
   assumes: bus outputs of edm_core, one cycle each, no wait states. */
`timescale 1ns/1ps
module edm_mem (
   input  wire logic        sys_clk,       // clock
   input  wire logic        nrst,          // reset, active low
   input  wire logic        hog,           // bench asks the other master to hold the bus
   input  wire logic [31:0] bus_addr_r,    // dma address
   input  wire logic        bus_rd_r,      // dma read
   input  wire logic        bus_wr_r,      // dma write
   output logic             bus_other_req, // other master request
   output logic [31:0]      last_rd,       // last read address
   output logic [31:0]      last_wr,       // last write address
   output logic [7:0]       n_rd           // reads seen
);
   // other master wants the bus only while told, so slow and prompt cases both occur
   assign bus_other_req = hog;
   // log every cycle; memory contents are not modelled
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         last_rd <= 32'h0000_0000;
         last_wr <= 32'h0000_0000;
         n_rd    <= 8'h00;
      end else begin
         if (bus_rd_r) last_rd <= bus_addr_r;
         if (bus_rd_r) n_rd <= n_rd + 8'h01;
         if (bus_wr_r) last_wr <= bus_addr_r;
      end
   end
endmodule : edm_mem

// >>> bench/edm_core_chk.sv
/* edm_core_chk: port-level assertions for edm_core.
   assumes: bound into edm_core; one clock domain. */
`timescale 1ns/1ps
module edm_core_chk #(
   parameter int NCH = 4                      // channel count
) (
   input wire logic              sys_clk,       // clock
   input wire logic              nrst,          // reset
   input wire edm_pkg::edm_swr_t sw_wr,         // software write
   input wire logic              bus_other_req, // other master
   input wire logic              nmi,           // nmi pulse
   input wire logic              hw_standby,    // standby
   input wire logic              bus_rd_r,      // read cycle
   input wire logic              bus_wr_r,      // write cycle
   input wire logic [1:0]        bus_ch_r,      // cycle owner
   input wire logic              xfer_end_r,    // end pulse
   input wire logic [NCH-1:0]    ch_en_r,       // enables
   input wire logic [NCH-1:0]    irq_r          // requests
);
   logic [1:0] wch_r; // owner of the last write cycle
   logic [1:0] sch_r; // channel field of the software write port, one cycle late
   // the end pulse comes after the write, so the owner must be remembered
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wch_r <= 2'h0;
         sch_r <= 2'h0;
      end else begin
         if (bus_wr_r) wch_r <= bus_ch_r;
         sch_r <= sw_wr.ch;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_rd; bus_rd_r; endsequence
   sequence s_wr; bus_wr_r && $stable(bus_ch_r); endsequence
   chk_rd_then_wr: assert property (s_rd |=> s_wr)
      else $error("read not followed by write of same channel");
   chk_wr_has_rd: assert property (bus_wr_r |-> $past(bus_rd_r))
      else $error("write without read");
   chk_end_disables: assert property (xfer_end_r |-> ##[0:2] !ch_en_r[wch_r])
      else $error("enable kept after end");
   chk_nmi_clears: assert property (nmi |=> ch_en_r == '0)
      else $error("nmi left a channel enabled");
   chk_stby_clears: assert property (hw_standby |=> ch_en_r == '0)
      else $error("standby left a channel enabled");
   chk_irq_no_en: assert property ((irq_r & ch_en_r) == '0)
      else $error("request with channel enabled");
   chk_other_holds: assert property (!bus_rd_r && !bus_wr_r && bus_other_req |=> !bus_rd_r)
      else $error("read while other master holds bus");
   chk_en_write: assert property (sw_wr.wr && sw_wr.sel == edm_pkg::SEL_MODE && sw_wr.data[0]
      && !nmi && !hw_standby |=> ch_en_r[sch_r])
      else $error("enable write lost");
endmodule : edm_core_chk
bind edm_core edm_core_chk #(.NCH(NCH)) i_edm_core_chk (.sys_clk, .nrst, .sw_wr, .bus_other_req, .nmi,
   .hw_standby, .bus_rd_r, .bus_wr_r, .bus_ch_r, .xfer_end_r, .ch_en_r, .irq_r);

// >>> bench/edm_core_bench.sv
/* edm_core_bench: self-checking bench for edm_core.
   assumes: edm_mem as far side, checker bound to the core. */
`timescale 1ns/1ps
module edm_core_bench;
   logic              sys_clk, nrst, sw_rd, hog, bus_other_req, nmi, hw_standby;
   edm_pkg::edm_swr_t sw_wr;
   logic [1:0]        sw_rd_ch, bus_ch_r;
   logic [2:0]        sw_rd_sel;
   logic [3:0]        xfer_req, ch_en_r, irq_r;
   logic [31:0]       rd_data_r, bus_addr_r, last_rd, last_wr;
   logic              bus_rd_r, bus_wr_r, bus_size_r, xfer_end_r;
   logic [7:0]        n_rd;
   int                err_count, n_tests;
   int                cyc = 0;
   edm_core i_edm_core (.sys_clk, .nrst, .sw_wr, .sw_rd, .sw_rd_ch, .sw_rd_sel, .xfer_req, .bus_other_req,
      .nmi, .hw_standby, .rd_data_r, .bus_addr_r, .bus_rd_r, .bus_wr_r, .bus_size_r, .bus_ch_r,
      .xfer_end_r, .ch_en_r, .irq_r);
   edm_mem i_edm_mem (.sys_clk, .nrst, .hog, .bus_addr_r, .bus_rd_r, .bus_wr_r, .bus_other_req,
      .last_rd, .last_wr, .n_rd);
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [1:0] ch, input logic [2:0] sel, input logic [31:0] d);
      @(posedge sys_clk);
      sw_wr <= '{wr: 1'b1, ch: ch, sel: sel, data: d};
      @(posedge sys_clk);
      sw_wr.wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [1:0] ch, input logic [2:0] sel, input logic [31:0] exp);
      @(posedge sys_clk);
      sw_rd     <= 1'b1;
      sw_rd_ch  <= ch;
      sw_rd_sel <= sel;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      @(negedge sys_clk);
      check(rd_data_r, exp);
   endtask : rdchk
   // bounded waits on the design's own cycles
   task automatic wait_rd();
      int k;
      k = 0;
      @(negedge sys_clk);
      while (bus_rd_r !== 1'b1 && k < 300) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 300) err_count++;
   endtask : wait_rd
   // sampled at the falling edge so the enable is settled; returns on a rising edge for the next drive
   task automatic wait_off(input int ch);
      int k;
      k = 0;
      @(negedge sys_clk);
      while (ch_en_r[ch] !== 1'b0 && k < 300) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 300) err_count++;
      @(posedge sys_clk);
   endtask : wait_off
   task automatic t_normal();
      wr(2'h0, edm_pkg::SEL_SAR, 32'h0000_0100);
      wr(2'h0, edm_pkg::SEL_DAR, 32'h0000_0200);
      wr(2'h0, edm_pkg::SEL_TCR, 32'h0000_0002);
      wr(2'h0, edm_pkg::SEL_ACR, 32'h0000_000B); // source up, destination down
      wr(2'h0, edm_pkg::SEL_MODE, 32'h0000_0013); // word size, irq enabled
      xfer_req <= 4'h1;
      wait_off(0);
      xfer_req <= 4'h0;
      check(n_rd, 32'h0000_0002);
      check(last_rd, 32'h0000_0102);
      check(last_wr, 32'h0000_01FE);
      check(bus_size_r, 32'h0000_0001);
      rdchk(2'h0, edm_pkg::SEL_SAR, 32'h0000_0104);
      rdchk(2'h0, edm_pkg::SEL_DAR, 32'h0000_01FC);
      rdchk(2'h0, edm_pkg::SEL_TCR, 32'h0000_0000);
      check(irq_r, 32'h0000_0001);
      rdchk(2'h0, 3'h5, 32'h0000_0000); // unmapped select reads zero
      wr(2'h0, edm_pkg::SEL_MODE, 32'h0000_0013);
      @(negedge sys_clk);
      check(irq_r, 32'h0000_0000);
      wr(2'h0, edm_pkg::SEL_MODE, 32'h0000_0012);
      $display("normal transfer test done");
   endtask : t_normal
   task automatic t_prio();
      hog <= 1'b1;
      wr(2'h1, edm_pkg::SEL_TCR, 32'h0000_0002);
      wr(2'h2, edm_pkg::SEL_TCR, 32'h0000_0001);
      wr(2'h1, edm_pkg::SEL_MODE, 32'h0000_0001);
      wr(2'h2, edm_pkg::SEL_MODE, 32'h0000_0001);
      xfer_req <= 4'h6;
      repeat (4) @(posedge sys_clk);
      check(n_rd, 32'h0000_0002);
      hog <= 1'b0;
      wait_rd();
      check(bus_ch_r, 32'h0000_0001);
      wait_rd();
      check(bus_ch_r, 32'h0000_0002);
      wait_rd();
      check(bus_ch_r, 32'h0000_0001);
      wait_off(1);
      xfer_req <= 4'h0;
      rdchk(2'h2, edm_pkg::SEL_TCR, 32'h0000_0000);
      $display("priority test done");
   endtask : t_prio
   task automatic t_nmi();
      wr(2'h3, edm_pkg::SEL_TCR, 32'h0004_0008);
      wr(2'h3, edm_pkg::SEL_MODE, 32'h0000_0021); // block mode
      xfer_req <= 4'h8;
      wait_rd();
      wait_rd();
      @(posedge sys_clk);
      nmi <= 1'b1;
      @(posedge sys_clk);
      nmi <= 1'b0;
      xfer_req <= 4'h0;
      @(negedge sys_clk);
      check(ch_en_r, 32'h0000_0000);
      rdchk(2'h3, edm_pkg::SEL_MODE, 32'h0000_0028);
      rdchk(2'h3, edm_pkg::SEL_TCR, 32'h0004_0006);
      $display("nmi test done");
   endtask : t_nmi
   // count stays 0 so only the repeat overflow can end the channel
   task automatic t_repeat();
      wr(2'h1, edm_pkg::SEL_SAR, 32'h0000_00FE);
      wr(2'h1, edm_pkg::SEL_ACR, 32'h0000_8208); // source up, low bit wraps, overflow stops
      wr(2'h1, edm_pkg::SEL_MODE, 32'h0000_0001);
      xfer_req <= 4'h2;
      wait_off(1);
      xfer_req <= 4'h0;
      check(last_rd, 32'h0000_00FF);
      rdchk(2'h1, edm_pkg::SEL_SAR, 32'h0000_00FE);
      rdchk(2'h1, edm_pkg::SEL_TCR, 32'h0000_0000);
      rdchk(2'h1, edm_pkg::SEL_MODE, 32'h0000_0004);
      $display("repeat area test done");
   endtask : t_repeat
   // burst with count 0 runs until halted by a 0-write
   task automatic t_burst();
      logic [7:0] n0;
      n0 = n_rd;
      wr(2'h2, edm_pkg::SEL_MODE, 32'h0000_00C1);
      xfer_req <= 4'h4;
      wait_rd();
      wr(2'h2, edm_pkg::SEL_MODE, 32'h0000_0000);
      @(negedge sys_clk);
      check(ch_en_r[2], 32'h0000_0001);
      wait_off(2);
      xfer_req <= 4'h0;
      check(n_rd - n0, 32'h0000_0002);
      rdchk(2'h2, edm_pkg::SEL_MODE, 32'h0000_00C0);
      $display("burst halt test done");
   endtask : t_burst
   task automatic t_standby();
      wr(2'h0, edm_pkg::SEL_TCR, 32'h0000_0010);
      wr(2'h0, edm_pkg::SEL_MODE, 32'h0000_0001);
      xfer_req <= 4'h1;
      wait_rd();
      @(posedge sys_clk);
      hw_standby <= 1'b1;
      @(posedge sys_clk);
      hw_standby <= 1'b0;
      xfer_req   <= 4'h0;
      @(negedge sys_clk);
      check(ch_en_r, 32'h0000_0000);
      $display("standby test done");
   endtask : t_standby
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   // hang guard, far above the 130 or so cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   // reset, then the tests in order
   initial begin
      nrst = 1'b0;
      sw_wr = '0;
      sw_rd = 1'b0;
      sw_rd_ch = 2'h0;
      sw_rd_sel = 3'h0;
      xfer_req = 4'h0;
      hog = 1'b0;
      nmi = 1'b0;
      hw_standby = 1'b0;
      err_count = 0;
      n_tests = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_normal();
      t_prio();
      t_nmi();
      t_standby();
      t_repeat();
      t_burst();
      end_of_test();
   end
endmodule : edm_core_bench
